// >>> common/image_two_pkg.sv
// Package: register map, field layout, reset values and codes for the target image.
package image_two_pkg;

    // ==========================================
    // Register offsets (byte addresses)
    localparam logic [11:0] BASE_OFFSET = 12'h12C;
    localparam logic [11:0] BOUND_OFFSET = 12'h130;
    localparam logic [11:0] XLATE_OFFSET = 12'h134;
    localparam logic [11:0] CONTROL_OFFSET = 12'h13C;

    // ==========================================
    // Control field positions
    localparam int ENABLE_BIT = 31;
    localparam int POSTED_BIT = 30;
    localparam int WIDTH_HI = 23;
    localparam int WIDTH_LO = 22;
    localparam int SPACE_HI = 18;
    localparam int SPACE_LO = 16;
    localparam int PROGRAM_BIT = 14;
    localparam int SUPER_BIT = 12;
    localparam int BLOCK_BIT = 8;
    localparam int PCI_SPACE_BIT = 0;
    localparam int ADDR_FIELD_LO = 16;

    // ==========================================
    // Reset values
    localparam logic [15:0] ADDR_FIELD_RESET = 16'h0000;
    localparam logic [1:0] WIDTH_RESET = 2'h2;
    localparam logic [2:0] SPACE_RESET = 3'h0;
    localparam logic BIT_RESET = 1'b0;

    // ==========================================
    // Codes
    typedef enum logic [1:0] {
        WIDTH_D8 = 2'h0,
        WIDTH_D16 = 2'h1,
        WIDTH_D32 = 2'h2,
        WIDTH_D64 = 2'h3
    } data_width_t;

    typedef enum logic [2:0] {
        SPACE_A16 = 3'h0,
        SPACE_A24 = 3'h1,
        SPACE_A32 = 3'h2,
        SPACE_RSV3 = 3'h3,
        SPACE_RSV4 = 3'h4,
        SPACE_CRCSR = 3'h5,
        SPACE_USER1 = 3'h6,
        SPACE_USER2 = 3'h7
    } addr_space_t;

    // Image control settings
    typedef struct packed {
        logic image_enable;
        logic posted_write_enable;
        data_width_t max_data_width;
        addr_space_t address_space_select;
        logic program_data_am_select;
        logic supervisor_am_select;
        logic block_transfer_select;
        logic pci_space_select;
    } image_ctrl_t;

    // Decoded request passed to the VMEbus cycle engine
    typedef struct packed {
        logic [31:0] vme_addr;
        addr_space_t space;
        data_width_t width;
        logic program_am;
        logic supervisor_am;
        logic single_blt;
        logic mblt;
        logic posted;
        logic is_write;
    } vme_request_t;

endpackage : image_two_pkg

// >>> rtl/pci_vme_image_two.sv
// Design: one PCI-to-VMEbus target image with APB registers and address decode.
// Behaviour
// - Block-transfer select acts only for A24 or A32 space with an 8, 16 or 32-bit width.
// - For A24 or A32 space with 64-bit width, MBLT may be used whatever block select says.
// - With I/O space selected, posted-write enable is ignored and every transfer is coupled.
// - Maximum data width sits in control bits 23:22, coded 8/16/32/64, resetting to 32-bit.
// - Address space sits in control bits 18:16; codes 011 and 100 are reserved.
// - Control bit 14 picks program (1) or data (0) AM code and resets to 0.
// - Control bit 12 picks supervisor (1) or non-privileged (0) AM code and resets to 0.
// - Control bit 8 picks single block transfers (1) or none (0) and resets to 0.
// - Control bit 0 picks PCI I/O space (1) or memory space (0).
// - The base field in bits 31:16 is the lowest decoded address; bits 15:0 read zero.
// - An address is claimed only when at or above base and strictly below bound.
// - A bound of zero removes the upper limit.
// - VMEbus address bits 31:16 are PCI bits 31:16 plus the offset, two's complement.
module pci_vme_image_two (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RESET,
    // APB register port
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // PCI target request
    input wire logic PCI_VALID,
    input wire logic PCI_IS_IO,
    input wire logic PCI_WRITE,
    input wire logic [31:0] PCI_ADDR,
    // Decode result toward the VMEbus engine
    output logic HIT,
    output image_two_pkg::vme_request_t VME_REQ
);

    // ==========================================
    // Registers
    logic [15:0] base_reg;
    logic [15:0] bound_reg;
    logic [15:0] xlate_reg;
    image_two_pkg::image_ctrl_t ctrl_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;
    logic hit_reg;
    image_two_pkg::vme_request_t req_reg;

    logic setup;
    logic wr_base;
    logic wr_bound;
    logic wr_xlate;
    logic wr_ctrl;
    logic mapped;
    logic [31:0] ctrl_word;
    logic [31:0] read_next;

    // One wait state: the access phase ends on the edge after the second access cycle.
    assign setup = PSEL && PENABLE && !pready_reg;
    assign mapped = (PADDR == image_two_pkg::BASE_OFFSET) ||
        (PADDR == image_two_pkg::BOUND_OFFSET) ||
        (PADDR == image_two_pkg::XLATE_OFFSET) ||
        (PADDR == image_two_pkg::CONTROL_OFFSET);
    assign wr_base = setup && PWRITE && (PADDR == image_two_pkg::BASE_OFFSET);
    assign wr_bound = setup && PWRITE && (PADDR == image_two_pkg::BOUND_OFFSET);
    assign wr_xlate = setup && PWRITE && (PADDR == image_two_pkg::XLATE_OFFSET);
    assign wr_ctrl = setup && PWRITE && (PADDR == image_two_pkg::CONTROL_OFFSET);

    // ==========================================
    // APB handshake
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg <= setup;
            pslverr_reg <= setup && !mapped;
        end
    end

    // ==========================================
    // Address window registers
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            base_reg <= image_two_pkg::ADDR_FIELD_RESET;
            bound_reg <= image_two_pkg::ADDR_FIELD_RESET;
            xlate_reg <= image_two_pkg::ADDR_FIELD_RESET;
        end else begin
            if (wr_base) begin
                base_reg <= PWDATA[31:image_two_pkg::ADDR_FIELD_LO];
            end
            if (wr_bound) begin
                bound_reg <= PWDATA[31:image_two_pkg::ADDR_FIELD_LO];
            end
            if (wr_xlate) begin
                xlate_reg <= PWDATA[31:image_two_pkg::ADDR_FIELD_LO];
            end
        end
    end

    // ==========================================
    // Control register
    // Enable, space and PCI space reset undefined; cleared here so the image starts idle.
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            ctrl_reg.image_enable <= image_two_pkg::BIT_RESET;
            ctrl_reg.posted_write_enable <= image_two_pkg::BIT_RESET;
            ctrl_reg.max_data_width <=
                image_two_pkg::data_width_t'(image_two_pkg::WIDTH_RESET);
            ctrl_reg.address_space_select <=
                image_two_pkg::addr_space_t'(image_two_pkg::SPACE_RESET);
            ctrl_reg.program_data_am_select <= image_two_pkg::BIT_RESET;
            ctrl_reg.supervisor_am_select <= image_two_pkg::BIT_RESET;
            ctrl_reg.block_transfer_select <= image_two_pkg::BIT_RESET;
            ctrl_reg.pci_space_select <= image_two_pkg::BIT_RESET;
        end else if (wr_ctrl) begin
            ctrl_reg.image_enable <= PWDATA[image_two_pkg::ENABLE_BIT];
            ctrl_reg.posted_write_enable <= PWDATA[image_two_pkg::POSTED_BIT];
            ctrl_reg.max_data_width <= image_two_pkg::data_width_t'(
                PWDATA[image_two_pkg::WIDTH_HI:image_two_pkg::WIDTH_LO]);
            ctrl_reg.address_space_select <= image_two_pkg::addr_space_t'(
                PWDATA[image_two_pkg::SPACE_HI:image_two_pkg::SPACE_LO]);
            ctrl_reg.program_data_am_select <= PWDATA[image_two_pkg::PROGRAM_BIT];
            ctrl_reg.supervisor_am_select <= PWDATA[image_two_pkg::SUPER_BIT];
            ctrl_reg.block_transfer_select <= PWDATA[image_two_pkg::BLOCK_BIT];
            ctrl_reg.pci_space_select <= PWDATA[image_two_pkg::PCI_SPACE_BIT];
        end
    end

    // ==========================================
    // Read mux
    always_comb begin
        ctrl_word = 32'h00000000;
        ctrl_word[image_two_pkg::ENABLE_BIT] = ctrl_reg.image_enable;
        ctrl_word[image_two_pkg::POSTED_BIT] = ctrl_reg.posted_write_enable;
        ctrl_word[image_two_pkg::WIDTH_HI:image_two_pkg::WIDTH_LO] = ctrl_reg.max_data_width;
        ctrl_word[image_two_pkg::SPACE_HI:image_two_pkg::SPACE_LO] =
            ctrl_reg.address_space_select;
        ctrl_word[image_two_pkg::PROGRAM_BIT] = ctrl_reg.program_data_am_select;
        ctrl_word[image_two_pkg::SUPER_BIT] = ctrl_reg.supervisor_am_select;
        ctrl_word[image_two_pkg::BLOCK_BIT] = ctrl_reg.block_transfer_select;
        ctrl_word[image_two_pkg::PCI_SPACE_BIT] = ctrl_reg.pci_space_select;
        case (PADDR)
            image_two_pkg::BASE_OFFSET: read_next = {base_reg, 16'h0000};
            image_two_pkg::BOUND_OFFSET: read_next = {bound_reg, 16'h0000};
            image_two_pkg::XLATE_OFFSET: read_next = {xlate_reg, 16'h0000};
            image_two_pkg::CONTROL_OFFSET: read_next = ctrl_word;
            default: read_next = 32'h00000000;
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            prdata_reg <= 32'h00000000;
        end else if (setup && !PWRITE) begin
            prdata_reg <= read_next;
        end
    end

    // ==========================================
    // Decode and translation
    logic space_match;
    logic above_base;
    logic below_bound;
    logic hit_next;
    logic blt_space;
    image_two_pkg::vme_request_t req_next;

    assign space_match = (PCI_IS_IO == ctrl_reg.pci_space_select);
    assign above_base = PCI_ADDR[31:16] >= base_reg;
    assign below_bound = (bound_reg == 16'h0000) || (PCI_ADDR[31:16] < bound_reg);
    assign hit_next = PCI_VALID && ctrl_reg.image_enable && space_match &&
        above_base && below_bound;
    assign blt_space = (ctrl_reg.address_space_select == image_two_pkg::SPACE_A24) ||
        (ctrl_reg.address_space_select == image_two_pkg::SPACE_A32);

    always_comb begin
        // Carry out of bit 31 is dropped on purpose: the sum wraps in 16 bits
        req_next.vme_addr = {16'(PCI_ADDR[31:16] + xlate_reg), PCI_ADDR[15:0]};
        req_next.space = ctrl_reg.address_space_select;
        req_next.width = ctrl_reg.max_data_width;
        req_next.program_am = ctrl_reg.program_data_am_select;
        req_next.supervisor_am = ctrl_reg.supervisor_am_select;
        req_next.single_blt = ctrl_reg.block_transfer_select && blt_space &&
            (ctrl_reg.max_data_width != image_two_pkg::WIDTH_D64);
        req_next.mblt = blt_space &&
            (ctrl_reg.max_data_width == image_two_pkg::WIDTH_D64);
        // I/O writes are never posted: a posted I/O write would lose its error status.
        req_next.posted = PCI_WRITE && ctrl_reg.posted_write_enable &&
            !ctrl_reg.pci_space_select;
        req_next.is_write = PCI_WRITE;
    end

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            hit_reg <= 1'b0;
            req_reg <= '0;
        end else begin
            hit_reg <= hit_next;
            if (hit_next) begin
                req_reg <= req_next;
            end
        end
    end

    assign PRDATA = prdata_reg;
    assign PREADY = pready_reg;
    assign PSLVERR = pslverr_reg;
    assign HIT = hit_reg;
    assign VME_REQ = req_reg;

    // ==========================================
    // Checks
    window_hit_a: assert property (@(posedge REF_CLK) disable iff (RESET)
        HIT |-> ($past(PCI_ADDR[31:16]) >= $past(base_reg)))
        else $error("hit below base");
    bound_limit_a: assert property (@(posedge REF_CLK) disable iff (RESET)
        (HIT && $past(bound_reg) != 16'h0000) |-> ($past(PCI_ADDR[31:16]) < $past(bound_reg)))
        else $error("hit at or above bound");
    enable_gate_a: assert property (@(posedge REF_CLK) disable iff (RESET)
        HIT |-> $past(ctrl_reg.image_enable))
        else $error("hit while disabled");
    addr_xlate_a: assert property (@(posedge REF_CLK) disable iff (RESET)
        HIT |-> (VME_REQ.vme_addr[31:16] == 16'($past(PCI_ADDR[31:16]) + $past(xlate_reg))))
        else $error("bad translated address");
    io_coupled_a: assert property (@(posedge REF_CLK) disable iff (RESET)
        (HIT && $past(PCI_IS_IO)) |-> !VME_REQ.posted)
        else $error("posted I/O write");
    blt_gate_a: assert property (@(posedge REF_CLK) disable iff (RESET)
        (HIT && VME_REQ.single_blt) |->
            (VME_REQ.space inside {image_two_pkg::SPACE_A24, image_two_pkg::SPACE_A32} &&
            VME_REQ.width != image_two_pkg::WIDTH_D64))
        else $error("block transfer outside legal setting");
    mblt_use_a: assert property (@(posedge REF_CLK) disable iff (RESET)
        (HIT && VME_REQ.width == image_two_pkg::WIDTH_D64 &&
            VME_REQ.space inside {image_two_pkg::SPACE_A24, image_two_pkg::SPACE_A32})
            |-> VME_REQ.mblt)
        else $error("missing multiplexed block transfer");
    posted_write_a: assert property (@(posedge REF_CLK) disable iff (RESET)
        (HIT && $past(PCI_WRITE) && $past(ctrl_reg.posted_write_enable) &&
            !$past(PCI_IS_IO)) |-> VME_REQ.posted)
        else $error("memory write not posted");
    ctrl_write_a: assert property (@(posedge REF_CLK) disable iff (RESET)
        wr_ctrl |=> (ctrl_reg.max_data_width == $past(PWDATA[23:22])))
        else $error("width field not stored");
    apb_ready_a: assert property (@(posedge REF_CLK) disable iff (RESET)
        (PSEL && PENABLE && !PREADY) |=> PREADY ##1 !PREADY)
        else $error("apb ready timing");

endmodule : pci_vme_image_two

// >>> verification/pci_master_model.sv
// Partner model: PCI bus master issuing single target address phases.
module pci_master_model (
    // Clock
    input wire logic clk,
    // PCI target request
    output logic valid,
    output logic is_io,
    output logic wr,
    output logic [31:0] addr
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        valid = 1'b0;
        is_io = 1'b0;
        wr = 1'b0;
        addr = 32'h00000000;
    end

    // ==========================================
    // One address phase per call
    // Lines are inverted after release so a stale address never passes as valid
    task automatic issue(input logic [31:0] a, input logic io, input logic w);
        @(posedge clk);
        valid <= 1'b1;
        addr <= a;
        is_io <= io;
        wr <= w;
        @(posedge clk);
        valid <= 1'b0;
        addr <= ~a;
        is_io <= ~io;
        wr <= ~w;
    endtask : issue
endmodule : pci_master_model

// >>> verification/pci_vme_image_two_tb_top.sv
// Testbench: register map, window decode, translation and mode flags of the image.
module pci_vme_image_two_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic pci_valid;
    logic pci_is_io;
    logic pci_write;
    logic [31:0] pci_addr;
    logic hit;
    image_two_pkg::vme_request_t vme_req;
    int mismatches = 0;
    int tests_run = 0;
    logic [31:0] ctl = 32'h00000000;
    logic [31:0] ofs = 32'h00000000;
    logic [31:0] rd;
    logic err;

    always #2 ref_clk = ~ref_clk;

    pci_vme_image_two pci_vme_image_two_inst (.REF_CLK(ref_clk), .RESET(reset),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .PCI_VALID(pci_valid),
        .PCI_IS_IO(pci_is_io), .PCI_WRITE(pci_write), .PCI_ADDR(pci_addr), .HIT(hit),
        .VME_REQ(vme_req));

    pci_master_model pci_master_model_inst (.clk(ref_clk), .valid(pci_valid),
        .is_io(pci_is_io), .wr(pci_write), .addr(pci_addr));

    // ==========================================
    // Report
    task automatic summarize();
        if (mismatches == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : summarize

    task automatic chk(input string name, input logic [47:0] exp, input logic [47:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // ==========================================
    // APB master: held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
            if (n > 20) begin
                $display("[FAIL] pready expected 1 seen 0");
                mismatches++;
                summarize();
            end
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
        apb(1'b0, a, 32'h00000000);
        chk("prdata", {16'h0000, exp}, {16'h0000, rd});
        chk("pslverr", {47'h0, exp_err}, {47'h0, err});
    endtask : rchk

    // ==========================================
    // Decode probe with expectation built from the programmed settings
    task automatic probe(input logic [31:0] a, input logic io, input logic w, input logic eh);
        image_two_pkg::vme_request_t r;
        logic ab;
        ab = (ctl[18:16] == 3'h1) || (ctl[18:16] == 3'h2);
        r.vme_addr = {a[31:16] + ofs[31:16], a[15:0]};
        r.space = image_two_pkg::addr_space_t'(ctl[18:16]);
        r.width = image_two_pkg::data_width_t'(ctl[23:22]);
        r.program_am = ctl[14];
        r.supervisor_am = ctl[12];
        r.single_blt = ab && (ctl[23:22] != 2'h3) && ctl[8];
        r.mblt = ab && (ctl[23:22] == 2'h3);
        r.posted = ctl[30] && !io && w;
        r.is_write = w;
        pci_master_model_inst.issue(a, io, w);
        #1;
        chk("hit", {47'h0, eh}, {47'h0, hit});
        if (eh) begin
            chk("vme_req", {5'h00, r}, {5'h00, vme_req});
        end
        // Hit stands one cycle; the request holds until the next hit
        @(posedge ref_clk);
        #1;
        chk("hit_drop", 48'h0, {47'h0, hit});
        if (eh) begin
            chk("vme_req_hold", {5'h00, r}, {5'h00, vme_req});
        end
    endtask : probe

    // ==========================================
    // Scenarios
    task automatic reset_values();
        rchk(image_two_pkg::BASE_OFFSET, 32'h00000000, 1'b0);
        rchk(image_two_pkg::BOUND_OFFSET, 32'h00000000, 1'b0);
        rchk(image_two_pkg::XLATE_OFFSET, 32'h00000000, 1'b0);
        rchk(image_two_pkg::CONTROL_OFFSET, 32'h00800000, 1'b0);
        apb(1'b1, 12'h138, 32'hFFFFFFFF);
        rchk(12'h138, 32'h00000000, 1'b1);
    endtask : reset_values

    task automatic field_masks();
        apb(1'b1, image_two_pkg::BASE_OFFSET, 32'hFFFFFFFF);
        rchk(image_two_pkg::BASE_OFFSET, 32'hFFFF0000, 1'b0);
        apb(1'b1, image_two_pkg::CONTROL_OFFSET, 32'hFFFFFFFF);
        rchk(image_two_pkg::CONTROL_OFFSET, 32'hC0C75101, 1'b0);
    endtask : field_masks

    task automatic window_edges();
        ofs = 32'h01000000;
        ctl = 32'h80800000;
        apb(1'b1, image_two_pkg::BASE_OFFSET, 32'h10000000);
        apb(1'b1, image_two_pkg::BOUND_OFFSET, 32'h20000000);
        apb(1'b1, image_two_pkg::XLATE_OFFSET, ofs);
        apb(1'b1, image_two_pkg::CONTROL_OFFSET, 32'h00800000);
        probe(32'h10001234, 1'b0, 1'b0, 1'b0);
        apb(1'b1, image_two_pkg::CONTROL_OFFSET, ctl);
        probe(32'h0FFFFFFF, 1'b0, 1'b0, 1'b0);
        probe(32'h10001234, 1'b0, 1'b0, 1'b1);
        probe(32'h1FFFFFFF, 1'b0, 1'b1, 1'b1);
        probe(32'h20000000, 1'b0, 1'b0, 1'b0);
        probe(32'h10000000, 1'b1, 1'b0, 1'b0);
        // Zero bound opens the top; carry out of bit 31 wraps
        apb(1'b1, image_two_pkg::BOUND_OFFSET, 32'h00000000);
        probe(32'hFFFF0010, 1'b0, 1'b0, 1'b1);
    endtask : window_edges

    task automatic mode_flags();
        apb(1'b1, image_two_pkg::BASE_OFFSET, 32'h00000000);
        for (int sp = 0; sp < 8; sp++) begin
            for (int w = 0; w < 4; w++) begin
                if (sp != 3 && sp != 4) begin
                    ctl = 32'hC0000100 | (32'(sp) << 16) | (32'(w) << 22) | (32'(w) << 12);
                    apb(1'b1, image_two_pkg::CONTROL_OFFSET, ctl);
                    probe(32'h00420000, 1'b0, 1'b1, 1'b1);
                    probe(32'h00430000, 1'b1, 1'b0, 1'b0);
                end
            end
        end
        ctl = 32'hC0015001;
        apb(1'b1, image_two_pkg::CONTROL_OFFSET, ctl);
        probe(32'h00440000, 1'b1, 1'b1, 1'b1);
        probe(32'h00450000, 1'b1, 1'b0, 1'b1);
    endtask : mode_flags

    initial begin
        repeat (6) @(posedge ref_clk);
        reset <= 1'b0;
        reset_values();
        field_masks();
        window_edges();
        mode_flags();
        summarize();
    end
endmodule : pci_vme_image_two_tb_top
